// ==== spg_consts.svh ====
/*
 * Constants of the SMBus register pager: offsets, field positions, reset values
 * and timing counts. Assumes inclusion by bare name from the pager sources.
 */
`ifndef SPG_CONSTS_SVH
`define SPG_CONSTS_SVH

// ----------------------------------------
// Global register offsets and fields
// ----------------------------------------
`define SPG_GLOBAL_LO 8'hef
`define SPG_REG_LANE_ID 8'hef
`define SPG_REG_CHAN_SEL 8'hfc
`define SPG_REG_BANK_SEL 8'hff
`define SPG_BANK_CHAN_BIT 0
`define SPG_BANK_CLR_BIT 2
`define SPG_BANK_SET_LSB 4
`define SPG_RESET_BYTE 8'h00
`define SPG_ADDR_BASE 7'h18

// ----------------------------------------
// Sizes and timing
// ----------------------------------------
`define SPG_CH_COUNT 8
`define SPG_SHARED_SETS 4
`define SPG_REG_DEPTH 16
`define SPG_CLK_NS 50
`define SPG_SCL_PERIOD_NS 400
`define SPG_QTR_CYC (`SPG_SCL_PERIOD_NS / (4 * `SPG_CLK_NS))

// ----------------------------------------
// Host controller register indices (byte address = index * 4)
// ----------------------------------------
`define SPG_H_CTRL 2'h0
`define SPG_H_TARGET 2'h1
`define SPG_H_DATA 2'h2
`define SPG_H_STATUS 2'h3
`define SPG_H_GO_BIT 0
`define SPG_H_READ_BIT 1

`endif

// ==== spg_pkg.sv ====
/*
 * Types of the SMBus register pager: state encodings of both ends.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package spg_pkg;
    typedef enum logic [3:0] {
        SPG_D_IDLE, SPG_D_ADDR, SPG_D_ACK_A, SPG_D_REGA, SPG_D_ACK_R,
        SPG_D_WDATA, SPG_D_ACK_W, SPG_D_RDATA, SPG_D_RACK
    } spg_dev_state_t;

    typedef enum logic [3:0] {
        SPG_H_IDLE, SPG_H_START, SPG_H_TXA, SPG_H_TXR, SPG_H_TXD,
        SPG_H_RSTART, SPG_H_TXA2, SPG_H_RX, SPG_H_STOP
    } spg_host_state_t;
endpackage : spg_pkg

`default_nettype wire

// ==== spg_if.sv ====
/*
 * Two-wire bus between the host end and the device end.
 * Assumes pull-ups: a line is low only while some party enables a low drive.
 */
`default_nettype none

interface spg_if;
    logic scl_h_out;
    logic scl_h_oe;
    logic sda_h_out;
    logic sda_h_oe;
    logic scl_d_out;
    logic scl_d_oe;
    logic sda_d_out;
    logic sda_d_oe;
    logic scl;
    logic sda;

    // Wired-AND with pull-up
    assign scl = ~((scl_h_oe & ~scl_h_out) | (scl_d_oe & ~scl_d_out));
    assign sda = ~((sda_h_oe & ~sda_h_out) | (sda_d_oe & ~sda_d_out));

    modport host (output scl_h_out, scl_h_oe, sda_h_out, sda_h_oe, input scl, sda);
    modport device (output scl_d_out, scl_d_oe, sda_d_out, sda_d_oe, input scl, sda);
endinterface : spg_if

`default_nettype wire

// ==== spg_device.sv ====
/*
 * Device end: SMBus slave with a banked byte register space.
 * Assumes a host on the two-wire bus whose clock is much slower than clk.
 */
`include "spg_consts.svh"
`default_nettype none

module spg_device
    import spg_pkg::*;
#(
    parameter int CH_COUNT = `SPG_CH_COUNT,
    parameter int REG_DEPTH = `SPG_REG_DEPTH,
    parameter logic [3:0] LANE_ID = 4'h5 // Arbitrary identification value
)(
    input wire logic clk,
    input wire logic rst,
    spg_if.device bus,
    input wire logic bus_role_strap,
    input wire logic [1:0] addr_strap_hi,
    input wire logic [1:0] addr_strap_lo,
    input wire logic load_req_n,
    output logic load_done_n,
    output logic [6:0] slave_addr,
    output logic [7:0] chan_select,
    output logic [7:0] bank_select
);
    localparam int AW = $clog2(REG_DEPTH);

    if (CH_COUNT < 1 || CH_COUNT > 8 || REG_DEPTH < 2 || REG_DEPTH > 239)
        $error("spg_device: unsupported CH_COUNT or REG_DEPTH");

    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] role_s;
    logic [1:0] req_s;
    logic [3:0] strap_s1;
    logic [3:0] strap_s2;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            role_s <= 2'h0;
            req_s <= 2'h3;
            strap_s1 <= 4'h0;
            strap_s2 <= 4'h0;
        end
        else
        begin
            scl_s <= {scl_s[1:0], bus.scl};
            sda_s <= {sda_s[1:0], bus.sda};
            role_s <= {role_s[0], bus_role_strap};
            req_s <= {req_s[0], load_req_n};
            strap_s1 <= {addr_strap_hi, addr_strap_lo};
            strap_s2 <= strap_s1;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic slave_only;
    logic regs_clr;

    assign scl_rise = scl_s[1] & ~scl_s[2];
    assign scl_fall = ~scl_s[1] & scl_s[2];
    assign start_det = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
    assign stop_det = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
    assign slave_only = role_s[1];
    assign regs_clr = slave_only & ~req_s[1];

    // ----------------------------------------
    // Strap capture and role
    // ----------------------------------------
    // Waits for the strap synchroniser to fill before the one-time capture
    logic [1:0] strap_wait;
    logic strap_taken;
    logic slave_en;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            strap_wait <= 2'h0;
            strap_taken <= 1'b0;
            slave_addr <= `SPG_ADDR_BASE;
        end
        else if (!strap_taken)
        begin
            strap_wait <= strap_wait + 2'h1;
            if (strap_wait == 2'h3)
            begin
                strap_taken <= 1'b1;
                slave_addr <= `SPG_ADDR_BASE + {3'h0, strap_s2};
            end
        end
    end

    // The EEPROM loader is not built: a load request completes at once
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            slave_en <= 1'b0;
            load_done_n <= 1'b1;
        end
        else if (slave_only)
        begin
            slave_en <= strap_taken;
            load_done_n <= req_s[1];
        end
        else if (!req_s[1])
        begin
            slave_en <= strap_taken;
            load_done_n <= ~strap_taken;
        end
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [7:0] ptr;
    logic [7:0] shift;
    logic wr_stb;
    logic [3:0] lane_rsvd;
    logic [7:0] shared_mem [`SPG_SHARED_SETS][REG_DEPTH];
    logic [7:0] chan_mem [CH_COUNT][REG_DEPTH];
    logic in_local;
    logic [AW-1:0] idx;
    logic [7:0] rd_data;

    assign in_local = ptr < 8'(REG_DEPTH);
    assign idx = ptr[AW-1:0];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lane_rsvd <= 4'h0;
            chan_select <= `SPG_RESET_BYTE;
            bank_select <= `SPG_RESET_BYTE;
        end
        else if (regs_clr)
        begin
            lane_rsvd <= 4'h0;
            chan_select <= `SPG_RESET_BYTE;
            bank_select <= `SPG_RESET_BYTE;
        end
        else if (wr_stb && ptr == `SPG_REG_LANE_ID)
            lane_rsvd <= shift[7:4];
        else if (wr_stb && ptr == `SPG_REG_CHAN_SEL)
            chan_select <= shift;
        else if (wr_stb && ptr == `SPG_REG_BANK_SEL)
            bank_select <= shift;
        else
            bank_select[`SPG_BANK_CLR_BIT] <= 1'b0;
    end

    // Self-clearing bank bit wipes every channel set
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            shared_mem <= '{default: '{default: `SPG_RESET_BYTE}};
            chan_mem <= '{default: '{default: `SPG_RESET_BYTE}};
        end
        else if (regs_clr)
        begin
            shared_mem <= '{default: '{default: `SPG_RESET_BYTE}};
            chan_mem <= '{default: '{default: `SPG_RESET_BYTE}};
        end
        else if (bank_select[`SPG_BANK_CLR_BIT])
            chan_mem <= '{default: '{default: `SPG_RESET_BYTE}};
        else if (wr_stb && in_local)
        begin
            if (bank_select[`SPG_BANK_CHAN_BIT])
            begin
                for (int c = 0; c < CH_COUNT; c++)
                    if (chan_select[c])
                        chan_mem[c][idx] <= shift;
            end
            else
                shared_mem[bank_select[5:4]][idx] <= shift;
        end
    end

    // Reads from a multi-channel selection return the lowest channel
    always_comb
    begin
        rd_data = 8'h00;
        if (ptr == `SPG_REG_LANE_ID)
            rd_data = {lane_rsvd, LANE_ID};
        else if (ptr == `SPG_REG_CHAN_SEL)
            rd_data = chan_select;
        else if (ptr == `SPG_REG_BANK_SEL)
            rd_data = bank_select;
        else if (in_local && !bank_select[`SPG_BANK_CHAN_BIT])
            rd_data = shared_mem[bank_select[5:4]][idx];
        else if (in_local)
        begin
            for (int c = CH_COUNT - 1; c >= 0; c--)
                if (chan_select[c])
                    rd_data = chan_mem[c][idx];
        end
    end

    // ----------------------------------------
    // Bus protocol engine
    // ----------------------------------------
    spg_dev_state_t state;
    logic [3:0] cnt;
    logic rw;
    logic nack;
    logic [7:0] tx;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= SPG_D_IDLE;
            cnt <= 4'h0;
            rw <= 1'b0;
            nack <= 1'b0;
            tx <= 8'h00;
            shift <= 8'h00;
            ptr <= 8'h00;
            wr_stb <= 1'b0;
            bus.sda_d_oe <= 1'b0;
            bus.sda_d_out <= 1'b0;
            bus.scl_d_oe <= 1'b0;
            bus.scl_d_out <= 1'b0;
        end
        else
        begin
            wr_stb <= 1'b0;
            if (stop_det || !slave_en)
            begin
                state <= SPG_D_IDLE;
                bus.sda_d_oe <= 1'b0;
            end
            else if (start_det)
            begin
                state <= SPG_D_ADDR;
                cnt <= 4'h0;
                bus.sda_d_oe <= 1'b0;
            end
            else if (scl_rise)
            begin
                if (state == SPG_D_ADDR || state == SPG_D_REGA || state == SPG_D_WDATA)
                begin
                    shift <= {shift[6:0], sda_s[1]};
                    cnt <= cnt + 4'h1;
                end
                if (state == SPG_D_RACK)
                    nack <= sda_s[1];
            end
            else if (scl_fall)
            begin
                case (state)
                    SPG_D_ADDR:
                        if (cnt == 4'h8)
                        begin
                            if (shift[7:1] == slave_addr)
                            begin
                                rw <= shift[0];
                                bus.sda_d_oe <= 1'b1;
                                state <= SPG_D_ACK_A;
                            end
                            else
                                state <= SPG_D_IDLE;
                        end
                    SPG_D_ACK_A:
                    begin
                        cnt <= 4'h0;
                        if (rw)
                        begin
                            tx <= rd_data;
                            bus.sda_d_oe <= ~rd_data[7];
                            cnt <= 4'h1;
                            state <= SPG_D_RDATA;
                        end
                        else
                        begin
                            bus.sda_d_oe <= 1'b0;
                            state <= SPG_D_REGA;
                        end
                    end
                    SPG_D_REGA:
                        if (cnt == 4'h8)
                        begin
                            ptr <= shift;
                            bus.sda_d_oe <= 1'b1;
                            state <= SPG_D_ACK_R;
                        end
                    SPG_D_ACK_R, SPG_D_ACK_W:
                    begin
                        bus.sda_d_oe <= 1'b0;
                        cnt <= 4'h0;
                        state <= SPG_D_WDATA;
                        if (state == SPG_D_ACK_W)
                            ptr <= ptr + 8'h01;
                    end
                    SPG_D_WDATA:
                        if (cnt == 4'h8)
                        begin
                            wr_stb <= 1'b1;
                            bus.sda_d_oe <= 1'b1;
                            state <= SPG_D_ACK_W;
                        end
                    SPG_D_RDATA:
                        if (cnt == 4'h8)
                        begin
                            bus.sda_d_oe <= 1'b0;
                            ptr <= ptr + 8'h01;
                            state <= SPG_D_RACK;
                        end
                        else
                        begin
                            bus.sda_d_oe <= ~tx[3'(7 - cnt)];
                            cnt <= cnt + 4'h1;
                        end
                    SPG_D_RACK:
                        if (nack)
                            state <= SPG_D_IDLE;
                        else
                        begin
                            tx <= rd_data;
                            bus.sda_d_oe <= ~rd_data[7];
                            cnt <= 4'h1;
                            state <= SPG_D_RDATA;
                        end
                    default:
                        state <= SPG_D_IDLE;
                endcase
            end
        end
    end
endmodule : spg_device

`default_nettype wire

// ==== spg_host.sv ====
/*
 * Host end: bus master that runs one-byte register writes and reads,
 * ordered over Avalon-MM. Assumes slaves that never stretch the clock.
 */
`include "spg_consts.svh"
`default_nettype none

module spg_host
    import spg_pkg::*;
#(
    parameter int QTR_CYC = `SPG_QTR_CYC
)(
    input wire logic clk,
    input wire logic rst,
    spg_if.host bus,
    input wire logic [1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest
);
    if (QTR_CYC < 1 || QTR_CYC > 255)
        $error("spg_host: QTR_CYC out of range");

    // ----------------------------------------
    // Avalon slave
    // ----------------------------------------
    logic busy;
    logic nack;
    logic go;
    logic rd_op;
    logic [6:0] tgt;
    logic [7:0] reg_addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic take;

    assign take = write && !waitrequest;

    // One wait cycle, then the answer
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            waitrequest <= 1'b1;
            readdata <= 32'h0;
        end
        else
        begin
            waitrequest <= !((read || write) && waitrequest);
            case (address)
                `SPG_H_TARGET: readdata <= {16'h0, reg_addr, 1'b0, tgt};
                `SPG_H_DATA: readdata <= {24'h0, rdata};
                `SPG_H_STATUS: readdata <= {30'h0, nack, busy};
                default: readdata <= {30'h0, rd_op, 1'b0};
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tgt <= 7'h0;
            reg_addr <= 8'h0;
            wdata <= 8'h0;
            rd_op <= 1'b0;
            go <= 1'b0;
        end
        else
        begin
            go <= 1'b0;
            if (take && address == `SPG_H_TARGET)
            begin
                tgt <= writedata[6:0];
                reg_addr <= writedata[15:8];
            end
            if (take && address == `SPG_H_DATA)
                wdata <= writedata[7:0];
            // A go while busy is dropped
            if (take && address == `SPG_H_CTRL && !busy)
            begin
                rd_op <= writedata[`SPG_H_READ_BIT];
                go <= writedata[`SPG_H_GO_BIT];
            end
        end
    end

    // ----------------------------------------
    // Bit engine
    // ----------------------------------------
    logic [1:0] sda_s;
    logic [7:0] div;
    logic tick;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] tx;
    spg_host_state_t state;

    assign tick = div == 8'(QTR_CYC - 1);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sda_s <= 2'h3;
            div <= 8'h0;
        end
        else
        begin
            sda_s <= {sda_s[0], bus.sda};
            div <= tick ? 8'h0 : div + 8'h01;
        end
    end

    // Each bit is four quarters: set data, raise clock, sample, lower clock
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= SPG_H_IDLE;
            busy <= 1'b0;
            nack <= 1'b0;
            q <= 2'h0;
            bitn <= 4'h0;
            tx <= 8'h0;
            rdata <= 8'h0;
            bus.scl_h_oe <= 1'b0;
            bus.sda_h_oe <= 1'b0;
            bus.scl_h_out <= 1'b0;
            bus.sda_h_out <= 1'b0;
        end
        else if (state == SPG_H_IDLE)
        begin
            if (go)
            begin
                busy <= 1'b1;
                nack <= 1'b0;
                q <= 2'h0;
                state <= SPG_H_START;
            end
        end
        else if (tick)
        begin
            q <= q + 2'h1;
            case (state)
                SPG_H_START, SPG_H_RSTART:
                    case (q)
                        2'h0: bus.sda_h_oe <= 1'b0;
                        2'h1: bus.scl_h_oe <= 1'b0;
                        2'h2: bus.sda_h_oe <= 1'b1;
                        default:
                        begin
                            bus.scl_h_oe <= 1'b1;
                            bitn <= 4'h0;
                            tx <= {tgt, state == SPG_H_RSTART};
                            state <= state == SPG_H_START ? SPG_H_TXA : SPG_H_TXA2;
                        end
                    endcase
                SPG_H_STOP:
                    case (q)
                        2'h0: bus.sda_h_oe <= 1'b1;
                        2'h1: bus.scl_h_oe <= 1'b0;
                        2'h2: bus.sda_h_oe <= 1'b0;
                        default:
                        begin
                            busy <= 1'b0;
                            state <= SPG_H_IDLE;
                        end
                    endcase
                SPG_H_TXA, SPG_H_TXR, SPG_H_TXD, SPG_H_TXA2, SPG_H_RX:
                    case (q)
                        2'h0:
                            if (bitn == 4'h8 || state == SPG_H_RX)
                                bus.sda_h_oe <= 1'b0;
                            else
                                bus.sda_h_oe <= ~tx[3'(7 - bitn)];
                        2'h1: bus.scl_h_oe <= 1'b0;
                        2'h2:
                            if (bitn == 4'h8 && state != SPG_H_RX)
                                nack <= sda_s[1];
                            else if (bitn != 4'h8 && state == SPG_H_RX)
                                rdata <= {rdata[6:0], sda_s[1]};
                        default:
                        begin
                            bus.scl_h_oe <= 1'b1;
                            bitn <= bitn + 4'h1;
                            if (bitn == 4'h8)
                            begin
                                bitn <= 4'h0;
                                if (state == SPG_H_RX || nack)
                                    state <= SPG_H_STOP;
                                else if (state == SPG_H_TXA)
                                begin
                                    tx <= reg_addr;
                                    state <= SPG_H_TXR;
                                end
                                else if (state == SPG_H_TXR && rd_op)
                                    state <= SPG_H_RSTART;
                                else if (state == SPG_H_TXR)
                                begin
                                    tx <= wdata;
                                    state <= SPG_H_TXD;
                                end
                                else if (state == SPG_H_TXA2)
                                    state <= SPG_H_RX;
                                else
                                    state <= SPG_H_STOP;
                            end
                        end
                    endcase
                default:
                    state <= SPG_H_IDLE;
            endcase
        end
    end
endmodule : spg_host

`default_nettype wire

// ==== spg_assertions.sv ====
/* Checker of the two-wire bus between the host and device ends.
   Assumes it sits beside spg_if in the bench, in the clk domain. */
`default_nettype none
module spg_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_h_out,
    input wire logic scl_h_oe,
    input wire logic sda_h_out,
    input wire logic sda_h_oe,
    input wire logic scl_d_out,
    input wire logic scl_d_oe,
    input wire logic sda_d_out,
    input wire logic sda_d_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Wire rules
    // ----------------------------------------
    sda_drain_a: assert property (sda_d_oe |-> !sda_d_out)
        else $error("device drives data high");
    scl_drain_a: assert property (scl_d_oe |-> !scl_d_out)
        else $error("device drives clock high");
    clock_quiet_a: assert property (!scl_d_oe)
        else $error("slave device pulls the clock");
    start_source_a: assert property (scl && $past(scl) && $fell(sda) |-> $rose(sda_h_oe))
        else $error("start not made by host");
    stop_source_a: assert property (scl && $past(scl) && $rose(sda) |-> $fell(sda_h_oe))
        else $error("stop not made by host");
    data_steady_a: assert property (scl && $past(scl) |-> $stable(sda_d_oe))
        else $error("device data moved while clock high");
    high_width_a: assert property ($rose(scl) |-> scl [*3])
        else $error("clock high too short");
    low_width_a: assert property ($fell(scl) |-> !scl [*3])
        else $error("clock low too short");
    cover property ($fell(sda) && scl);
    cover property ($rose(sda_d_oe));
    cover property ($rose(sda) && scl);
endmodule : spg_assertions
`default_nettype wire

// ==== smbus_register_access_pager_test.sv ====
/* Bench of the register pager: host end over Avalon drives the device end.
   Assumes spg_pkg, spg_if, both ends and the checker compiled first. */
`default_nettype none
module smbus_register_access_pager_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, rd = 0, wr = 0, load_req_n = 1, role = 1;
    logic [1:0] adr = 0, hi = 0, lo = 0;
    logic [31:0] wd = 0, rdat;
    wire logic [31:0] readdata;
    wire logic waitrequest, load_done_n;
    wire logic [6:0] slave_addr;
    wire logic [7:0] chan_select, bank_select;
    int bad_count = 0, n_tests = 0;
    logic [7:0] q[$];
    spg_if bus ();
    spg_host spg_host_i (.clk(clk), .rst(rst), .bus(bus), .address(adr), .read(rd),
        .write(wr), .writedata(wd), .readdata(readdata), .waitrequest(waitrequest));
    spg_device spg_device_i (.clk(clk), .rst(rst), .bus(bus), .bus_role_strap(role),
        .addr_strap_hi(hi), .addr_strap_lo(lo), .load_req_n(load_req_n),
        .load_done_n(load_done_n), .slave_addr(slave_addr), .chan_select(chan_select),
        .bank_select(bank_select));
    spg_assertions spg_assertions_i (.clk(clk), .rst(rst), .scl_h_out(bus.scl_h_out),
        .scl_h_oe(bus.scl_h_oe), .sda_h_out(bus.sda_h_out), .sda_h_oe(bus.sda_h_oe),
        .scl_d_out(bus.scl_d_out), .scl_d_oe(bus.scl_d_oe), .sda_d_out(bus.sda_d_out),
        .sda_d_oe(bus.sda_d_oe), .scl(bus.scl), .sda(bus.sda));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] g, e);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    // Request held until the edge that sees waitrequest low
    task automatic av(input logic [1:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rdat = readdata;
        rd <= 0;
        wr <= 0;
    endtask : av
    // nk flips the address bit so the device must refuse
    task automatic xfer(input logic [7:0] r, d, input logic rdop, nk);
        av(2'h1, 1, {16'h0, r, 1'b0, slave_addr ^ {6'h0, nk}});
        av(2'h2, 1, {24'h0, d});
        av(2'h0, 1, {30'h0, rdop, 1'b1});
        rdat = 1;
        while (rdat[0] !== 1'b0)
            av(2'h3, 0, 0);
        chk({7'h0, rdat[1]}, {7'h0, nk});
        if (rdop)
        begin
            q.push_back(d);
            av(2'h2, 0, 0);
        end
    endtask : xfer
    // ----------------------------------------
    // Processes
    // ----------------------------------------
    always #25 clk = ~clk;
    always @(posedge clk)
        if (rd && waitrequest === 1'b0 && adr == 2'h2)
            chk(readdata[7:0], q.pop_front());
    initial
    begin
        #3000000;
        bad_count++;
        conclude();
    end
    initial
    begin
        logic [7:0] a, b;
        void'($urandom(15));
        a = 8'($urandom);
        b = 8'($urandom);
        hi <= 2'($urandom);
        lo <= 2'($urandom);
        repeat (10) @(posedge clk);
        rst <= 0;
        repeat (20) @(posedge clk);
        chk({1'b0, slave_addr}, 8'h18 + {hi, lo});
        xfer(8'hef, 8'h05, 1, 0);
        xfer(8'hef, 8'h3a, 0, 0);
        xfer(8'hef, 8'h35, 1, 0);
        xfer(8'hff, 8'h01, 0, 0);
        xfer(8'hfc, 8'h01, 0, 0);
        xfer(8'h03, a, 0, 0);
        xfer(8'hfc, 8'h02, 0, 0);
        chk(chan_select, 8'h02);
        xfer(8'h03, b, 0, 0);
        xfer(8'hfc, 8'h01, 0, 0);
        xfer(8'h03, a, 1, 0);
        xfer(8'hff, 8'h00, 0, 0);
        chk(bank_select, 8'h00);
        xfer(8'h03, 8'h00, 1, 0);
        xfer(8'hff, 8'h00, 1, 0);
        xfer(8'hff, 8'h30, 0, 0);
        xfer(8'h03, b, 0, 0);
        xfer(8'h03, b, 1, 0);
        xfer(8'hfc, 8'h01, 1, 0);
        xfer(8'h03, a, 0, 1);
        xfer(8'hff, 8'h05, 0, 0);
        xfer(8'hff, 8'h01, 1, 0);
        xfer(8'h03, 8'h00, 1, 0);
        load_req_n <= 0;
        repeat (10) @(posedge clk);
        chk({7'h0, load_done_n}, 8'h00);
        load_req_n <= 1;
        repeat (10) @(posedge clk);
        xfer(8'hfc, 8'h00, 1, 0);
        // ----------------------------------------
        // Load role: deaf until a load request
        // ----------------------------------------
        role <= 0;
        rst <= 1;
        repeat (3) @(posedge clk);
        rst <= 0;
        repeat (20) @(posedge clk);
        chk({7'h0, load_done_n}, 8'h01);
        load_req_n <= 0;
        repeat (10) @(posedge clk);
        chk({7'h0, load_done_n}, 8'h00);
        xfer(8'hef, 8'h05, 1, 0);
        conclude();
    end
endmodule : smbus_register_access_pager_test
`default_nettype wire
